// ==== design/smc_top.sv ====
// System mode, clock select and module stop control with APB slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "smc_defines.svh"

module smc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        top_mode_pin,
	input  wire logic [2:0]  lower_mode_pins,
	input  wire logic        sleep_req,
	input  wire logic [23:0] ram_addr,
	output logic             core_clk_en,
	output logic             periph_clk_en,
	output logic             bus_clk_en,
	output logic [15:0]      module_halt_a,
	output logic [15:0]      module_halt_b,
	output logic [15:0]      module_halt_c,
	output logic             dma_stop_bit,
	output logic             serial0_stop_bit,
	output logic [4:0]       ram_bank_stop_bit,
	output logic             bus_ctrl_stop,
	output logic             io_port_stop,
	output logic             ram_access_stopped
);

	// ==========================================================
	// Register state
	logic [15:0]            clk_sel_r;
	logic [15:0]            stop_a_r;
	logic [15:0]            stop_b_r;
	logic [15:0]            stop_c_r;
	logic                   pready_r;
	logic                   pslverr_r;
	logic [31:0]            prdata_r;
	logic [2:0]             div_cnt_r;
	logic                   core_en_r;
	logic                   peri_en_r;
	logic                   bus_en_r;
	logic                   ram_blk_r;
	smc_pkg::smc_pwr_e      pwr_r;
	smc_pkg::smc_pwr_e      pwr_nxt;

	// ==========================================================
	// APB decode
	wire logic        setup_ph;
	wire logic        access_ph;
	wire logic        addr_ok;
	wire logic [23:0] reg_idx;
	wire logic        sel_mode;
	wire logic        sel_clk;
	wire logic        sel_a;
	wire logic        sel_b;
	wire logic        sel_c;
	wire logic        reg_hit;
	wire logic        wr_take;
	wire logic [15:0] lane_mask;
	wire logic [15:0] wr_val;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable && pready_r;
	assign reg_idx   = paddr[25:2];
	assign addr_ok   = (paddr[31:26] == 6'h00) && (paddr[1:0] == 2'h0);
	assign sel_mode  = addr_ok && (reg_idx == `SMC_IDX_MODE);
	assign sel_clk   = addr_ok && (reg_idx == `SMC_IDX_CLK);
	assign sel_a     = addr_ok && (reg_idx == `SMC_IDX_STOP_A);
	assign sel_b     = addr_ok && (reg_idx == `SMC_IDX_STOP_B);
	assign sel_c     = addr_ok && (reg_idx == `SMC_IDX_STOP_C);
	assign reg_hit   = sel_mode || sel_clk || sel_a || sel_b || sel_c;
	assign wr_take   = access_ph && pwrite && !pslverr_r;
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wr_val    = pwdata[15:0];

	// ==========================================================
	// Mode pin latch
	wire logic               mode_capture;
	smc_pkg::smc_mode_s      mode_view;
	wire logic [15:0]        mode_word;

	assign mode_capture = setup_ph && !pwrite && sel_mode;

	smc_mode_latch u_mode_latch (
		.clk             (pclk),
		.rst_n           (presetn),
		.capture         (mode_capture),
		.top_mode_pin    (top_mode_pin),
		.lower_mode_pins (lower_mode_pins),
		.mode_view       (mode_view)
	);

	assign mode_word = {mode_view.top, 3'h0, mode_view.sel, 8'h00};

	// ==========================================================
	// Read mux
	wire logic [15:0] rd_word;
	wire logic [15:0] rd_mode;
	wire logic [15:0] rd_clk;
	wire logic [15:0] rd_a;
	wire logic [15:0] rd_b;
	wire logic [15:0] rd_c;

	// Unassigned bits and unmapped reads give zero
	assign rd_mode = mode_word & `SMC_MASK_MODE;
	assign rd_clk  = clk_sel_r & `SMC_MASK_CLK;
	assign rd_a    = stop_a_r & `SMC_MASK_STOP_A;
	assign rd_b    = stop_b_r & `SMC_MASK_STOP_B;
	assign rd_c    = stop_c_r & `SMC_MASK_STOP_C;

	assign rd_word =
		sel_mode ? rd_mode :
		sel_clk  ? rd_clk :
		sel_a    ? rd_a :
		sel_b    ? rd_b :
		sel_c    ? rd_c :
		16'h0000;

	// ==========================================================
	// Masked write values
	wire logic [15:0] clk_wr;
	wire logic [15:0] a_wr;
	wire logic [15:0] b_wr;
	wire logic [15:0] c_wr;

	assign clk_wr = ((clk_sel_r & ~lane_mask) | (wr_val & lane_mask))
		& `SMC_MASK_CLK;
	assign a_wr = ((stop_a_r & ~lane_mask) | (wr_val & lane_mask))
		& `SMC_MASK_STOP_A;
	assign b_wr = ((stop_b_r & ~lane_mask) | (wr_val & lane_mask))
		& `SMC_MASK_STOP_B;
	assign c_wr = ((stop_c_r & ~lane_mask) | (wr_val & lane_mask))
		& `SMC_MASK_STOP_C;

	// ==========================================================
	// APB response, one registered access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup_ph;
		end
	end

	// Error and data captured at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			pslverr_r <= !reg_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata_r <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
		end
	end

	// ==========================================================
	// Control registers; mode register writes fall through
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel_r <= `SMC_RST_CLK;
		end else if (wr_take && sel_clk) begin
			clk_sel_r <= clk_wr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_a_r <= `SMC_RST_STOP_A;
		end else if (wr_take && sel_a) begin
			stop_a_r <= a_wr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_b_r <= `SMC_RST_STOP_B;
		end else if (wr_take && sel_b) begin
			stop_b_r <= b_wr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_c_r <= `SMC_RST_STOP_C;
		end else if (wr_take && sel_c) begin
			stop_c_r <= c_wr;
		end
	end

	// ==========================================================
	// Clock rate enables; pclk is the twice-input rate
	smc_pkg::smc_clk_sel_s clk_sel;

	assign clk_sel = '{
		core:   clk_sel_r[`SMC_CORE_SEL_LSB +: 3],
		periph: clk_sel_r[`SMC_PERI_SEL_LSB +: 3],
		bus:    clk_sel_r[`SMC_BUS_SEL_LSB +: 3]
	};

	function automatic logic rate_en(input logic [2:0] code,
		input logic [2:0] cnt);
		logic en;
		en = 1'b0;
		unique case (code)
			3'h0, 3'h1: en = 1'b1;
			3'h2:       en = (cnt[0] == 1'b0);
			3'h3:       en = (cnt[1:0] == 2'h0);
			default:    en = (cnt == 3'h0);
		endcase
		return en;
	endfunction

	wire logic core_en_nxt;
	wire logic peri_en_nxt;
	wire logic bus_en_nxt;

	assign core_en_nxt = rate_en(clk_sel.core, div_cnt_r);
	assign peri_en_nxt = rate_en(clk_sel.periph, div_cnt_r);
	assign bus_en_nxt  = rate_en(clk_sel.bus, div_cnt_r);

	// Deep stop also silences the bus clock
	wire logic deep_now;

	assign deep_now = (pwr_r == smc_pkg::SMC_DEEP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 3'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_en_r <= 1'b0;
			peri_en_r <= 1'b0;
			bus_en_r  <= 1'b0;
		end else begin
			core_en_r <= core_en_nxt;
			peri_en_r <= peri_en_nxt;
			bus_en_r  <= bus_en_nxt && !deep_now;
		end
	end

	// ==========================================================
	// All-module clock stop on sleep
	wire logic all_peri_stopped;
	wire logic deep_ok;
	wire logic peri_a_all;
	wire logic peri_b_all;
	wire logic peri_c_all;

	assign peri_a_all = (stop_a_r & `SMC_PERI_STOP_A) == `SMC_PERI_STOP_A;
	assign peri_b_all = (stop_b_r & `SMC_MASK_STOP_B) == `SMC_MASK_STOP_B;
	assign peri_c_all = (stop_c_r & `SMC_PERI_STOP_C) == `SMC_PERI_STOP_C;
	assign all_peri_stopped = peri_a_all && peri_b_all && peri_c_all;
	assign deep_ok = stop_a_r[`SMC_ALL_STOP_EN_BIT] && all_peri_stopped
		&& sleep_req;

	always_comb begin
		pwr_nxt = pwr_r;
		unique case (pwr_r)
			smc_pkg::SMC_RUN: begin
				if (deep_ok) begin
					pwr_nxt = smc_pkg::SMC_DEEP;
				end
			end
			smc_pkg::SMC_DEEP: begin
				if (!deep_ok) begin
					pwr_nxt = smc_pkg::SMC_RUN;
				end
			end
			default: pwr_nxt = smc_pkg::SMC_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_r <= smc_pkg::SMC_RUN;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	// ==========================================================
	// RAM bank range check, bit 4 lowest address
	wire logic [4:0] bank_hit;

	genvar gb;
	generate
		for (gb = 0; gb < `SMC_RAM_BANKS; gb++) begin : g_bank
			localparam logic [23:0] LO = `SMC_RAM_BASE
				+ 24'(`SMC_RAM_BANKS - 1 - gb) * `SMC_RAM_BANK_SIZE;
			localparam logic [23:0] HI = LO + `SMC_RAM_BANK_SIZE;
			assign bank_hit[gb] = (ram_addr >= LO) && (ram_addr < HI)
				&& stop_c_r[`SMC_RAM_LSB + gb];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_blk_r <= 1'b0;
		end else begin
			ram_blk_r <= |bank_hit;
		end
	end

	// ==========================================================
	// Outputs from flip-flops; bus_ctrl_stop and io_port_stop decode pwr_r
	assign pready             = pready_r;
	assign prdata             = prdata_r;
	assign pslverr            = pslverr_r;
	assign core_clk_en        = core_en_r;
	assign periph_clk_en      = peri_en_r;
	assign bus_clk_en         = bus_en_r;
	assign module_halt_a      = stop_a_r;
	assign module_halt_b      = stop_b_r;
	assign module_halt_c      = stop_c_r;
	assign dma_stop_bit       = stop_a_r[`SMC_DMA_BIT];
	assign serial0_stop_bit   = stop_b_r[`SMC_SCI0_BIT];
	assign ram_bank_stop_bit  = stop_c_r[`SMC_RAM_LSB +: 5];
	assign bus_ctrl_stop      = deep_now;
	assign io_port_stop       = deep_now;
	assign ram_access_stopped = ram_blk_r;

endmodule // smc_top
`default_nettype wire

// ==== design/smc_defines.svh ====
// Constants: offsets, field positions, masks, reset values, RAM bank map and mode select encodings
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define SMC_IDX_MODE      24'hfffdc0
`define SMC_IDX_CLK       24'hfffdc4
`define SMC_IDX_STOP_A    24'hfffdc8
`define SMC_IDX_STOP_B    24'hfffdca
`define SMC_IDX_STOP_C    24'hfffdcc

// ==========================================================
// Field positions
`define SMC_MODE_TOP_BIT  15
`define SMC_MODE_SEL_LSB  8
`define SMC_CORE_SEL_LSB  8
`define SMC_PERI_SEL_LSB  4
`define SMC_BUS_SEL_LSB   0
`define SMC_ALL_STOP_EN_BIT 15
`define SMC_DMA_BIT       13
`define SMC_SCI0_BIT      8
`define SMC_RAM_LSB       0
`define SMC_RAM_BANKS     5

// ==========================================================
// Implemented bit masks
`define SMC_MASK_MODE     16'h8f00
`define SMC_MASK_CLK      16'h0777
`define SMC_MASK_STOP_A   16'hb329
`define SMC_MASK_STOP_B   16'h97c0
`define SMC_MASK_STOP_C   16'hfc1f
`define SMC_PERI_STOP_A   16'h3329
`define SMC_PERI_STOP_C   16'hfc00

// ==========================================================
// Reset values
`define SMC_RST_CLK       16'h0111
`define SMC_RST_STOP_A    16'h3329
`define SMC_RST_STOP_B    16'h97c0
`define SMC_RST_STOP_C    16'hfc00

// ==========================================================
// RAM bank map
`define SMC_RAM_BASE      24'hff2000
`define SMC_RAM_BANK_SIZE 24'h002000

// ==========================================================
// Mode select encodings
`define SMC_MDS_MODE2     4'hc
`define SMC_MDS_MODE4     4'h2
`define SMC_MDS_MODE5     4'h1
`define SMC_MDS_MODE6     4'h5
`define SMC_MDS_MODE7     4'h4
`define SMC_MDS_OTHER     4'h0

`endif

// ==== design/smc_pkg.sv ====
// Types shared by the system mode and clock stop control block
package smc_pkg;

	typedef struct packed {
		logic [2:0] core;
		logic [2:0] periph;
		logic [2:0] bus;
	} smc_clk_sel_s;

	typedef struct packed {
		logic       top;
		logic [3:0] sel;
	} smc_mode_s;

	typedef enum logic [1:0] {
		SMC_RUN  = 2'b00,
		SMC_DEEP = 2'b01
	} smc_pwr_e;

endpackage

// ==== design/smc_mode_latch.sv ====
// Mode pin latch and mode select encoder
`timescale 1ns/1ns
`default_nettype none
`include "smc_defines.svh"

module smc_mode_latch (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              capture,
	input  wire logic              top_mode_pin,
	input  wire logic [2:0]        lower_mode_pins,
	output smc_pkg::smc_mode_s     mode_view
);

	logic               held_r;
	smc_pkg::smc_mode_s held_val_r;
	smc_pkg::smc_mode_s live_val;
	logic [3:0]         live_sel;

	always_comb begin
		unique case (lower_mode_pins)
			3'b010:  live_sel = `SMC_MDS_MODE2;
			3'b100:  live_sel = `SMC_MDS_MODE4;
			3'b101:  live_sel = `SMC_MDS_MODE5;
			3'b110:  live_sel = `SMC_MDS_MODE6;
			3'b111:  live_sel = `SMC_MDS_MODE7;
			default: live_sel = `SMC_MDS_OTHER;
		endcase
	end

	assign live_val  = '{top: top_mode_pin, sel: live_sel};
	assign mode_view = held_r ? held_val_r : live_val;

	// First read captures; only reset frees the latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held_r     <= 1'b0;
			held_val_r <= '0;
		end else if (capture && !held_r) begin
			held_r     <= 1'b1;
			held_val_r <= live_val;
		end
	end

endmodule // smc_mode_latch
`default_nettype wire

// ==== test/smc_assertions.sv ====
// Port checks for the mode, clock select and module stop block
`timescale 1ns/1ns
`default_nettype none
module smc_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        sleep_req,
	input wire logic [23:0] ram_addr,
	input wire logic [15:0] module_halt_a,
	input wire logic [15:0] module_halt_b,
	input wire logic [15:0] module_halt_c,
	input wire logic        dma_stop_bit,
	input wire logic        serial0_stop_bit,
	input wire logic [4:0]  ram_bank_stop_bit,
	input wire logic        bus_ctrl_stop,
	input wire logic        io_port_stop,
	input wire logic        ram_access_stopped
);
	// ==========
	// Helpers
	logic [23:0] ram_off;
	logic        ram_hit;
	logic        bad_addr;
	logic        deep_cond;
	assign ram_off = ram_addr - 24'hff2000;
	assign ram_hit = ram_addr >= 24'hff2000 && ram_addr <= 24'hffbfff
		&& module_halt_c[3'd4 - ram_off[15:13]];
	assign bad_addr = !(paddr inside {32'h03fff700, 32'h03fff710,
		32'h03fff720, 32'h03fff728, 32'h03fff730});
	assign deep_cond = module_halt_a[15] && sleep_req
		&& (module_halt_a & 16'h3329) == 16'h3329
		&& module_halt_b == 16'h97c0 && module_halt_c[15:10] == 6'h3f;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	// ==========
	// Assertions
	chk_ready_answer: assert property (setup_s |=> answer_s)
		else $error("pready not one cycle after setup");
	chk_err_unmapped: assert property (setup_s and bad_addr |=>
		pslverr && prdata == 32'h0) else $error("unmapped not refused");
	chk_err_mapped: assert property (setup_s and !bad_addr |=>
		!pslverr) else $error("mapped access refused");
	chk_halt_hold: assert property (!(psel && penable && pwrite) |=>
		$stable(module_halt_a) && $stable(module_halt_b)
		&& $stable(module_halt_c)) else $error("halt changed without write");
	chk_unused_zero: assert property ((module_halt_a & 16'h4cd6) == 0
		&& (module_halt_b & 16'h683f) == 0 && (module_halt_c & 16'h03e0) == 0)
		else $error("unassigned stop bit set");
	chk_dma_map: assert property (dma_stop_bit == module_halt_a[13])
		else $error("dma stop bit wrong");
	chk_serial_map: assert property (serial0_stop_bit == module_halt_b[8])
		else $error("serial0 stop bit wrong");
	chk_ram_map: assert property (ram_bank_stop_bit == module_halt_c[4:0])
		else $error("ram bank stop bits wrong");
	chk_deep_stop: assert property (1'b1 |=> bus_ctrl_stop == $past(deep_cond)
		&& io_port_stop == bus_ctrl_stop) else $error("deep stop wrong");
	chk_ram_block: assert property (1'b1 |=>
		ram_access_stopped == $past(ram_hit)) else $error("ram block wrong");
endmodule // smc_assertions
bind smc_top smc_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pready, .prdata, .pslverr, .sleep_req, .ram_addr, .module_halt_a,
	.module_halt_b, .module_halt_c, .dma_stop_bit, .serial0_stop_bit,
	.ram_bank_stop_bit, .bus_ctrl_stop, .io_port_stop, .ram_access_stopped);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the mode, clock select and module stop block
`timescale 1ns/1ns
`default_nettype none
module tb;
	// ==========
	// Signals and model
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0]  pstrb;
	logic        top_mode_pin, sleep_req, core_clk_en, periph_clk_en;
	logic        bus_clk_en, dma_stop_bit, serial0_stop_bit, bus_ctrl_stop;
	logic        io_port_stop, ram_access_stopped;
	logic [2:0]  lower_mode_pins;
	logic [23:0] ram_addr;
	logic [15:0] module_halt_a, module_halt_b, module_halt_c;
	logic [4:0]  ram_bank_stop_bit;
	int          err_total, n_checks, seed;
	logic [31:0] mdl[5];
	logic [31:0] adr[5] = '{32'h03fff700, 32'h03fff710, 32'h03fff720,
		32'h03fff728, 32'h03fff730};
	logic [31:0] msk[5] = '{32'h0, 32'h0777, 32'hb329, 32'h97c0, 32'hfc1f};
	logic [31:0] rstv[5] = '{32'h0, 32'h0111, 32'h3329, 32'h97c0, 32'hfc00};
	logic [31:0] bad[4] = '{32'h03fff704, 32'h03fff712, 32'h43fff720,
		32'h03fff740};
	logic [3:0]  enc[8] = '{4'h0, 4'h0, 4'hc, 4'h0, 4'h2, 4'h1, 4'h5, 4'h4};
	smc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .top_mode_pin, .lower_mode_pins,
		.sleep_req, .ram_addr, .core_clk_en, .periph_clk_en, .bus_clk_en,
		.module_halt_a, .module_halt_b, .module_halt_c, .dma_stop_bit,
		.serial0_stop_bit, .ram_bank_stop_bit, .bus_ctrl_stop, .io_port_stop,
		.ram_access_stopped);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ==========
	// Tasks
	task automatic results;
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, d,
		input logic [3:0] s, output logic [31:0] rd, output logic er);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			err_total++;
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wreg(input int i, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] rd, bm;
		logic        er;
		bm = {16'h0, {8{s[1]}}, {8{s[0]}}} & msk[i];
		mdl[i] = (mdl[i] & ~bm) | (d & bm);
		apb(1'b1, adr[i], d, s, rd, er);
		check("write error", 0, er);
	endtask
	task automatic rreg(input int i);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, adr[i], 0, 4'h0, rd, er);
		check("read data", mdl[i], rd);
		check("halt a", mdl[2], module_halt_a);
		check("halt b", mdl[3], module_halt_b);
		check("halt c", mdl[4], module_halt_c);
		check("stop bits", {mdl[2][13], mdl[3][8], mdl[4][4:0]},
			{dma_stop_bit, serial0_stop_bit, ram_bank_stop_bit});
	endtask
	task automatic rst;
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		mdl = rstv;
	endtask
	// ==========
	// Scenarios
	initial begin
		logic [31:0] rd;
		logic        er, tp;
		int          nc, np, nb, p, i;
		seed = 1;
		{psel, penable, pwrite, paddr, pwdata, pstrb, sleep_req} = '0;
		{top_mode_pin, lower_mode_pins, ram_addr, presetn} = '0;
		rst();
		for (int r = 1; r < 5; r++) rreg(r);
		for (int c = 0; c < 8; c++) begin
			wreg(1, (c << 8) | (c << 4) | c, 4'h3);
			{nc, np, nb} = '0;
			repeat (16) begin
				@(posedge pclk);
				if (core_clk_en === 1'b1) nc++;
				if (periph_clk_en === 1'b1) np++;
				if (bus_clk_en === 1'b1) nb++;
			end
			p = c < 2 ? 1 : c == 2 ? 2 : c == 3 ? 4 : 8;
			check("core enables", 16 / p, nc);
			check("periph enables", 16 / p, np);
			check("bus enables", 16 / p, nb);
		end
		repeat (12) begin
			i = 1 + {$random(seed)} % 4;
			wreg(i, $random(seed), 4'($random(seed)));
			rreg(i);
		end
		foreach (bad[j]) begin
			apb(1'b1, bad[j], 32'hffff, 4'h3, rd, er);
			check("error flag", 1, er);
			apb(1'b0, bad[j], 0, 4'h0, rd, er);
			check("error read", 0, rd);
			check("error flag", 1, er);
		end
		rreg(2);
		for (int m = 0; m < 8; m++) begin
			tp = 1'($random(seed));
			top_mode_pin <= tp;
			lower_mode_pins <= 3'(m);
			rst();
			mdl[0] = {16'h0, tp, 3'h0, enc[m], 8'h0};
			wreg(0, 32'hffff, 4'h3);
			rreg(0);
			top_mode_pin <= ~tp;
			lower_mode_pins <= ~3'(m);
			rreg(0);
		end
		wreg(2, 32'hb329, 4'h3);
		sleep_req <= 1'b1;
		repeat (3) @(posedge pclk);
		check("bus stop", 32'h6, {bus_ctrl_stop, io_port_stop, bus_clk_en});
		wreg(3, 32'h17c0, 4'h3);
		@(posedge pclk);
		check("bus stop", 0, bus_ctrl_stop);
		wreg(3, 32'h97c0, 4'h3);
		wreg(2, 32'h3329, 4'h3);
		@(posedge pclk);
		check("bus stop", 0, io_port_stop);
		sleep_req <= 1'b0;
		foreach (enc[q]) begin
			wreg(4, $random(seed), 4'h3);
			for (int b = 0; b < 6; b++) begin
				ram_addr <= 24'hff2000 + 24'(b * 'h2000 + {$random(seed)} % 'h2000);
				repeat (2) @(posedge pclk);
				check("ram stop", b < 5 && mdl[4][4 - b], ram_access_stopped);
			end
		end
		results();
	end
endmodule // tb
`default_nettype wire
